// File: rtl/linear_reg_enable_control.sv
// enable control for the two linear regulators
`timescale 1ns/100ps
`default_nettype none

// Operation
// R01: reg1 select bits 4..0 let matching control input drive reg1 enable.
// R02: reg1 selects only act when its config is 111 and soft enable 10.
// R03: several selected inputs combine by logical OR into reg1 enable.
// R04: reg2 config field bits 7:5 is read-only; writes ignored.
// R05: reg2 config 000 keeps off; 001 on whenever battery/system supply present.
// R06: codes 010, 011, 100 turn reg2 on at 0, 25, 50 percent of boot.
// R07: code 111 hands reg2 to soft enable after 100 percent; 101/110 reserved.
// R08: soft enable 00 off, 01 on, 10 pin-controlled; host avoids 11.
// R09: reg1 select bits 7..5 behave like the lower select bits.
// R10: reg2 soft enable matters only under software-control config.
// R11: reserved codes leave the regulator disabled.
module linear_reg_enable_control #(
  parameter logic [2:0] reg1_enable_config = linear_reg_enable_pkg::reg1_config_default,
  parameter logic [2:0] reg2_enable_config = linear_reg_enable_pkg::reg2_config_default
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output var  logic [7:0]  reg_rdata,
  input  wire logic [1:0]  reg1_soft_enable,
  input  wire logic [7:0]  multipurpose_control_input,
  input  wire logic        battery_or_system_supply,
  input  wire logic [1:0]  boot_progress,
  output var  logic        first_linear_reg_en,
  output var  logic        second_linear_reg_en
);
  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // boot_progress: 0 start, 1 reached 25%, 2 reached 50%, 3 complete
  // pin decoding shared by both regulators' pin modes
  function automatic logic pin_or(input logic [7:0] sel, input logic [7:0] pins);
    // R03: or of selected
    pin_or = |(sel & pins);
  endfunction : pin_or

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] mpc_meta_reg;
  logic [7:0] mpc_sync_reg;
  logic [2:0] misc_meta_reg;
  logic [2:0] misc_sync_reg;
  // pins are asynchronous, so two stages before any use
  // each pin bit is independent, so skew between pin bits is harmless;
  // only the two progress bits form a word and need the filter below
  always_ff @(posedge ref_clk) begin
    mpc_meta_reg  <= multipurpose_control_input;
    mpc_sync_reg  <= mpc_meta_reg;
    misc_meta_reg <= {battery_or_system_supply, boot_progress};
    misc_sync_reg <= misc_meta_reg;
  end

  // ----------------------------------------------------------------
  // boot progress filter
  // ----------------------------------------------------------------
  // the progress bits are synchronised separately, so a step from 1 to 2
  // may read as 3 or 0 for one clock; a code is taken only once it has
  // read the same on two clocks in a row, which costs one clock of lag
  // but keeps a stray 3 from handing control to software too early
  logic [1:0] prog_prev_reg;
  logic [1:0] prog_prev_next;
  logic [1:0] progress_reg;
  logic [1:0] progress_next;
  // next filtered code
  always_comb begin
    prog_prev_next = misc_sync_reg[1:0];
    progress_next  = progress_reg;
    if (misc_sync_reg[1:0] == prog_prev_reg) begin
      progress_next = misc_sync_reg[1:0];
    end
  end

  // filter state, back to boot start on reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prog_prev_reg <= linear_reg_enable_pkg::boot_start;
      progress_reg  <= linear_reg_enable_pkg::boot_start;
    end else begin
      prog_prev_reg <= prog_prev_next;
      progress_reg  <= progress_next;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] reg1_sel_reg;
  logic [7:0] reg1_sel_next;
  logic [7:0] reg2_sel_reg;
  logic [7:0] reg2_sel_next;
  logic [1:0] soft2_reg;
  logic [1:0] soft2_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  // writes and read mux
  // a read and a write in one cycle return the old contents, since the
  // read mux looks at the registers, not at their next values; the
  // config bits of the reg2 enable register come from the factory
  // parameter and are never stored, so no write can reach them
  always_comb begin
    reg1_sel_next = reg1_sel_reg;
    reg2_sel_next = reg2_sel_reg;
    soft2_next    = soft2_reg;
    rdata_next    = rdata_reg;
    if (reg_wr) begin
      case (reg_addr)
        // R01: reg1 select store
        // R09: upper select bits
        linear_reg_enable_pkg::reg1_pin_select_addr: reg1_sel_next = reg_wdata;
        // R04: config bits dropped
        linear_reg_enable_pkg::reg2_enable_addr: soft2_next = reg_wdata[1:0];
        linear_reg_enable_pkg::reg2_pin_select_addr: reg2_sel_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        linear_reg_enable_pkg::reg1_pin_select_addr: rdata_next = reg1_sel_reg;
        // R04: config readable
        linear_reg_enable_pkg::reg2_enable_addr:
          rdata_next = {reg2_enable_config, 3'h0, soft2_reg};
        linear_reg_enable_pkg::reg2_pin_select_addr: rdata_next = reg2_sel_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg1_sel_reg <= linear_reg_enable_pkg::reg1_pin_sel_reset;
      reg2_sel_reg <= linear_reg_enable_pkg::reg2_pin_sel_reset;
      soft2_reg    <= linear_reg_enable_pkg::soft_enable_reset;
      rdata_reg    <= 8'h00;
    end else begin
      reg1_sel_reg <= reg1_sel_next;
      reg2_sel_reg <= reg2_sel_next;
      soft2_reg    <= soft2_next;
      rdata_reg    <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // enable decisions
  // ----------------------------------------------------------------
  logic en1_reg;
  logic en1_next;
  logic en2_reg;
  logic en2_next;
  logic supply_ok;
  assign supply_ok = misc_sync_reg[2];

  // both enables are registered and, but for reg1_soft_enable, decided from synchronised inputs,
  // so a pin change shows on an enable three clocks later; a reserved
  // factory code or a soft code of 11 always yields an off regulator
  // rather than a guess at an undefined encoding
  always_comb begin
    en1_next = 1'b0;
    if (reg1_enable_config == linear_reg_enable_pkg::cfg_soft) begin
      case (reg1_soft_enable)
        linear_reg_enable_pkg::soft_off: en1_next = 1'b0;
        linear_reg_enable_pkg::soft_on:  en1_next = 1'b1;
        // R02: pin mode gate
        linear_reg_enable_pkg::soft_pin: en1_next = pin_or(reg1_sel_reg, mpc_sync_reg);
        // R11: reserved reg1 soft code off
        default: en1_next = 1'b0;
      endcase
    end
    en2_next = 1'b0;
    case (reg2_enable_config)
      // R05: fixed off or on
      linear_reg_enable_pkg::cfg_disabled:  en2_next = 1'b0;
      linear_reg_enable_pkg::cfg_always_on: en2_next = supply_ok;
      // R06: sequenced turn-on points
      // 0% is the very start of boot, so no progress is needed
      linear_reg_enable_pkg::cfg_seq_0pct:  en2_next = 1'b1;
      linear_reg_enable_pkg::cfg_seq_25pct:
        en2_next = (progress_reg >= linear_reg_enable_pkg::boot_quarter);
      linear_reg_enable_pkg::cfg_seq_50pct:
        en2_next = (progress_reg >= linear_reg_enable_pkg::boot_half);
      // R07: software after completion
      linear_reg_enable_pkg::cfg_soft: begin
        // R10: soft field only here
        if (progress_reg == linear_reg_enable_pkg::boot_done) begin
          case (soft2_reg)
            // R08: soft enable decode
            linear_reg_enable_pkg::soft_off: en2_next = 1'b0;
            linear_reg_enable_pkg::soft_on:  en2_next = 1'b1;
            linear_reg_enable_pkg::soft_pin: en2_next = pin_or(reg2_sel_reg, mpc_sync_reg);
            // R11: reserved soft code off
            default: en2_next = 1'b0;
          endcase
        end
      end
      // R11: reserved config off
      default: en2_next = 1'b0;
    endcase
  end

  // regulators start off after reset
  // outputs leave straight from these flops, so no decode glitch
  // ever reaches a regulator enable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en1_reg <= 1'b0;
      en2_reg <= 1'b0;
    end else begin
      en1_reg <= en1_next;
      en2_reg <= en2_next;
    end
  end
  assign first_linear_reg_en  = en1_reg;
  assign second_linear_reg_en = en2_reg;
endmodule : linear_reg_enable_control

`default_nettype wire

// File: rtl/linear_reg_enable_pkg.sv
// constants for the linear regulator enable control block
package linear_reg_enable_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] reg1_pin_select_addr = 8'h54;
  localparam logic [7:0] reg2_enable_addr     = 8'h55;
  localparam logic [7:0] reg2_pin_select_addr = 8'h58;
  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          enable_config_lsb   = 5;
  localparam int          soft_enable_lsb     = 0;
  localparam logic [7:0]  reg1_pin_sel_reset  = 8'h00;
  localparam logic [7:0]  reg2_pin_sel_reset  = 8'h00;
  localparam logic [1:0]  soft_enable_reset   = 2'h0;
  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [2:0] cfg_disabled   = 3'h0;
  localparam logic [2:0] cfg_always_on  = 3'h1;
  localparam logic [2:0] cfg_seq_0pct   = 3'h2;
  localparam logic [2:0] cfg_seq_25pct  = 3'h3;
  localparam logic [2:0] cfg_seq_50pct  = 3'h4;
  localparam logic [2:0] cfg_soft       = 3'h7;
  localparam logic [1:0] soft_off       = 2'h0;
  localparam logic [1:0] soft_on        = 2'h1;
  localparam logic [1:0] soft_pin       = 2'h2;
  // boot progress codes as seen on the progress input
  localparam logic [1:0] boot_start     = 2'h0;
  localparam logic [1:0] boot_quarter   = 2'h1;
  localparam logic [1:0] boot_half      = 2'h2;
  localparam logic [1:0] boot_done      = 2'h3;
  // default factory configuration, arbitrary
  localparam logic [2:0] reg1_config_default = 3'h7;
  localparam logic [2:0] reg2_config_default = 3'h7;
endpackage : linear_reg_enable_pkg

// File: testbench/linear_reg_enable_control_asserts.sv
// checker for the regulator enable ports and the register read data
`timescale 1ns/100ps
`default_nettype none
module linear_reg_enable_checker #(
  parameter logic [2:0] reg2_enable_config = 3'h7
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] reg1_soft_enable,
  input wire logic [7:0] multipurpose_control_input,
  input wire logic [1:0] boot_progress,
  input wire logic       first_linear_reg_en,
  input wire logic       second_linear_reg_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // pin control with every pin low
  sequence s_pins_idle;
    (reg1_soft_enable == 2'h2 && multipurpose_control_input == 8'h00)[*4];
  endsequence
  property p_pin_or; s_pins_idle |=> !first_linear_reg_en; endproperty
  property p_soft_off; (reg1_soft_enable == 2'h0)[*4] |=> !first_linear_reg_en; endproperty
  property p_soft_on; (reg1_soft_enable == 2'h1)[*4] |=> first_linear_reg_en; endproperty
  property p_reset;
    disable iff (1'b0) rst |=> !first_linear_reg_en && !second_linear_reg_en;
  endproperty
  property p_unmapped;
    reg_rd && !(reg_addr inside {8'h54, 8'h55, 8'h58}) |=> reg_rdata == 8'h00;
  endproperty
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  property p_cfg_ro;
    reg_rd && reg_addr == 8'h55 |=> reg_rdata[7:2] == {reg2_enable_config, 3'h0};
  endproperty
  property p_boot;
    (reg2_enable_config == 3'h7 && boot_progress != 2'h3)[*6] |=> !second_linear_reg_en;
  endproperty
  a_pin_or: assert property (p_pin_or) else $error("reg1 on with pins low");
  a_soft_off: assert property (p_soft_off) else $error("reg1 on while off");
  a_soft_on: assert property (p_soft_on) else $error("reg1 off while on");
  a_reset: assert property (p_reset) else $error("enable during reset");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_cfg_ro: assert property (p_cfg_ro) else $error("config field wrong");
  a_boot: assert property (p_boot) else $error("reg2 on before boot end");
endmodule : linear_reg_enable_checker
bind linear_reg_enable_control linear_reg_enable_checker #(
  .reg2_enable_config(reg2_enable_config)) chk (.ref_clk(ref_clk), .rst(rst),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .reg1_soft_enable(reg1_soft_enable), .boot_progress(boot_progress),
  .multipurpose_control_input(multipurpose_control_input),
  .first_linear_reg_en(first_linear_reg_en), .second_linear_reg_en(second_linear_reg_en));
`default_nettype wire

// File: testbench/control_pin_host.sv
// host model driving the control pins
`timescale 1ns/100ps
`default_nettype none
module control_pin_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] pattern,
  output var  logic [7:0] pins
);
  // pins move just after the edge, a cycle late
  initial pins = 8'h00;
  always @(posedge ref_clk) pins <= #1 pattern;
endmodule : control_pin_host
`default_nettype wire

// File: testbench/linear_reg_enable_control_test.sv
// self-checking bench for the regulator enable control
`timescale 1ns/100ps
`default_nettype none
module linear_reg_enable_control_test;
  logic       ref_clk, rst, reg_wr, reg_rd, supply, en1, en2;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pattern, pins, sel;
  logic [1:0] soft1, soft2, boot;
  int         err_total, checks, seed;
  linear_reg_enable_control DUT (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg1_soft_enable(soft1), .multipurpose_control_input(pins),
    .battery_or_system_supply(supply), .boot_progress(boot),
    .first_linear_reg_en(en1), .second_linear_reg_en(en2));
  control_pin_host host (.ref_clk(ref_clk), .pattern(pattern), .pins(pins));
  // one extra instance per other reg2 factory code, sharing all inputs
  logic [6:0] en2_cfg;
  for (genvar c = 0; c < 7; c++) begin : g_cfg
    linear_reg_enable_control #(.reg2_enable_config(3'(c))) seq_dut (.ref_clk(ref_clk),
      .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(), .reg1_soft_enable(soft1),
      .multipurpose_control_input(pins), .battery_or_system_supply(supply),
      .boot_progress(boot), .first_linear_reg_en(), .second_linear_reg_en(en2_cfg[c]));
  end
  // expected reg2 enable for the sequenced and fixed factory codes
  function automatic logic exp_seq(input int c, input logic [1:0] b, input logic s);
    case (c)
      1: return s;
      2: return 1'b1;
      3: return b >= 2'h1;
      4: return b >= 2'h2;
      default: return 1'b0;
    endcase
  endfunction : exp_seq
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  // one access, strobe held for a single edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    step(1);
    {reg_wr, reg_rd} = 2'b00;
    step(1);
  endtask : acc
  // expected enable: off, on, or OR of the selected pins
  function automatic logic exp_en(input logic [1:0] s, input logic [7:0] m, p);
    return s == 2'h1 || (s == 2'h2 && (m & p) != 8'h00);
  endfunction : exp_en
  initial begin
    #20000;
    err_total++;
    test_done();
  end
  initial begin
    seed = 32'h59cd;
    {reg_wr, reg_rd, reg_addr, reg_wdata, pattern, soft1, boot} = '0;
    {rst, supply} = 2'b11;
    step(8);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, i == 0 ? 8'h54 : i == 1 ? 8'h58 : i == 2 ? 8'h10 : 8'h55, 8'h00);
      step(1);
      cmp(reg_rdata, i == 3 ? 8'he0 : 8'h00);
    end
    // reserved soft code, read-only bits written
    boot = 2'h3;
    acc(1'b1, 8'h55, 8'hff);
    acc(1'b0, 8'h55, 8'h00);
    step(3);
    cmp(reg_rdata, 8'he3);
    cmp({7'h0, en2}, 8'h00);
    for (int i = 0; i < 30; i++) begin
      sel = i == 5 ? 8'hff : $random(seed);
      pattern = i < 4 ? 8'h00 : $random(seed);
      boot = i < 6 ? 2'h3 : $random(seed);
      supply = 1'($random(seed));
      // host never writes soft code 11 here
      soft1 = 2'(i % 3);
      soft2 = 2'((i + 1) % 3);
      acc(1'b1, 8'h54, sel);
      acc(1'b1, 8'h58, ~sel);
      acc(1'b1, 8'h55, {6'h00, soft2});
      step(4);
      cmp({7'h0, en1}, {7'h0, exp_en(soft1, sel, pattern)});
      cmp({7'h0, en2}, {7'h0, boot == 2'h3 && exp_en(soft2, ~sel, pattern)});
      for (int c = 0; c < 7; c++) cmp({7'h0, en2_cfg[c]}, {7'h0, exp_seq(c, boot, supply)});
    end
    test_done();
  end
endmodule : linear_reg_enable_control_test
`default_nettype wire
